/* rkc_ctrl.sv */
// Functional notes
// - gap elapsed marks next character new message
// - hold root or node diagnostics role
// - factory restore sets keying defaults, power
// - standalone restore: high alarm, all mask
// - chassis restore: low alarm, major mask
// - key command holds until unkey command
// - key-up delay before keying transmitter
// - output power limited 20 to 37
// - simulator enable and address 0 to 80
// - frequencies in 6.25 kHz steps
// - receive time-out raises event 12
// - release delay holds transmitter after unkey
// - signal-to-noise refreshed every two seconds
// - alarm report code, class, more, step
// - transmit time-out unkeys transmitter
// - after time-out wait for request removal
// - unit address between 10000 and 65000
// - signal strength clamped -50 to -120
// - modem selects 9600, 19200 or analog
// - clear-to-send follows request after delay, or follows receive data in CTS key mode
// - key on received character when enabled
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "rkc_defs.svh"
module rkc_ctrl import rkc_pkg::*; #(
  parameter int MS_CYCLES = `RKC_MS_NS / `RKC_CLK_NS,
  parameter int SEC_MS = `RKC_SEC_MS,
  parameter int MIN_SEC = `RKC_MIN_SEC,
  parameter logic [31:0] RX_FREQ_DEF = 32'h00010000,
  parameter logic [31:0] TX_FREQ_DEF = 32'h00010000,
  parameter logic [15:0] UNIT_DEF = 16'h2710
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // keying lines
  input wire logic ptt_i,
  input wire logic rts_i,
  output logic cts_o,
  output logic tx_key_o,
  // data port and receiver
  input wire logic char_rx_i,
  input wire logic rf_data_i,
  output logic new_msg_o,
  // supervision
  input wire logic [31:0] alarm_evt_i,
  input wire logic [5:0] snr_i,
  input wire logic [7:0] rssi_i,
  output logic alarm_o
);
  localparam int SNR_SEC = `RKC_SNR_SEC;
  rkc_ap_t ap_q;
  rkc_dly_t dly_q;
  rkc_key_st_t st_q, st_d;
  rkc_modem_t modem_q;
  logic rd_done_q, rd_stall, wr_en;
  logic [31:0] rdata_q, rd_mux;
  logic [7:0] ctrl_q, tot_q, rxto_q, gap_cnt, cts_cnt, rx_cnt;
  logic [8:0] ku_cnt, tot_cnt;
  logic [31:0] mask_q, rxf_q, txf_q, evt_q, evt_set, gated;
  logic [5:0] pwr_q, snr_q;
  logic [15:0] unit_q;
  logic [6:0] sim_q;
  logic [7:0] rssi_q;
  logic [4:0] ptr_q, cur_code;
  logic [16:0] ms_cnt_q;
  logic [9:0] sec_cnt_q;
  logic [5:0] min_cnt_q;
  logic [1:0] snr_div_q;
  logic ms_tick, sec_tick, min_tick;
  logic ptt_m_q, ptt_s_q, rts_m_q, rts_s_q;
  logic key_cmd_q, lock_q, data_act_q, first_q, new_msg_q, req, tx_on;
  logic tot_fire, rxto_fire, gap_done, more, none;
  logic w_ctrl, w_cmd, w_dly, w_tout, w_mask, w_pwr, w_rxf, w_txf, w_unit;
  logic w_modem, w_evt, w_rpt, c_init, c_solo, c_chas;

  // clamp a value into a range
  function automatic logic [15:0] rkc_clamp(input logic [15:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // next pending event after a start code, wrapping
  function automatic logic [4:0] rkc_next(input logic [31:0] ev, input logic [4:0] s);
    logic [4:0] r;
    logic [4:0] k;
    logic hit;
    r = s;
    hit = 1'b0;
    for (int i = 1; i <= 32; i++)
    begin
      k = s + 5'(i);
      if (!hit && ev[k])
      begin
        r = k;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {ptt_m_q, ptt_s_q, rts_m_q, rts_s_q} <= 4'h0;
    else
      {ptt_m_q, ptt_s_q, rts_m_q, rts_s_q} <= {ptt_i, ptt_m_q, rts_i, rts_m_q};
  end

  // millisecond, second and minute ticks
  assign ms_tick = (ms_cnt_q == 17'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (sec_cnt_q == 10'(SEC_MS - 1));
  assign min_tick = sec_tick && (min_cnt_q == 6'(MIN_SEC - 1));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_cnt_q <= 17'h0;
      sec_cnt_q <= 10'h0;
      min_cnt_q <= 6'h0;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 17'h0 : ms_cnt_q + 17'h1;
      if (ms_tick)
        sec_cnt_q <= sec_tick ? 10'h0 : sec_cnt_q + 10'h1;
      if (sec_tick)
        min_cnt_q <= min_tick ? 6'h0 : min_cnt_q + 6'h1;
    end
  end

  // bus slave: reads take one wait state, writes none
  assign rd_stall = ap_q.vld && !ap_q.wr && !rd_done_q;
  assign hreadyout = !rd_stall;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign wr_en = ap_q.vld && ap_q.wr;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= '0;
      rd_done_q <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      if (hready)
        ap_q <= '{addr: haddr[7:0], wr: hwrite, vld: hsel && htrans[1]};
      rd_done_q <= rd_stall;
      if (rd_stall)
        rdata_q <= rd_mux;
    end
  end

  // write decode
  assign w_ctrl = wr_en && (ap_q.addr == `RKC_A_CTRL);
  assign w_cmd = wr_en && (ap_q.addr == `RKC_A_CMD);
  assign w_dly = wr_en && (ap_q.addr == `RKC_A_DLY);
  assign w_tout = wr_en && (ap_q.addr == `RKC_A_TOUT);
  assign w_mask = wr_en && (ap_q.addr == `RKC_A_MASK);
  assign w_pwr = wr_en && (ap_q.addr == `RKC_A_PWR);
  assign w_rxf = wr_en && (ap_q.addr == `RKC_A_RXF);
  assign w_txf = wr_en && (ap_q.addr == `RKC_A_TXF);
  assign w_unit = wr_en && (ap_q.addr == `RKC_A_UNIT);
  assign w_modem = wr_en && (ap_q.addr == `RKC_A_MODEM);
  assign w_evt = wr_en && (ap_q.addr == `RKC_A_EVT);
  assign w_rpt = wr_en && (ap_q.addr == `RKC_A_RPT);
  assign c_init = w_cmd && hwdata[`RKC_K_INIT];
  assign c_solo = w_cmd && hwdata[`RKC_K_SOLO];
  assign c_chas = w_cmd && hwdata[`RKC_K_CHAS];

  // configuration registers and restore commands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `RKC_CTRL_RST;
      dly_q <= '0;
      tot_q <= `RKC_TOT_DEF;
      rxto_q <= 8'h0;
      mask_q <= `RKC_MASK_SOLO;
      pwr_q <= `RKC_PWR_DEF;
      rxf_q <= RX_FREQ_DEF;
      txf_q <= TX_FREQ_DEF;
      unit_q <= UNIT_DEF;
      sim_q <= 7'h0;
      modem_q <= MD_ANALOG;
    end
    else
    begin
      if (w_ctrl)
        ctrl_q <= hwdata[7:0];
      if (w_dly)
        dly_q <= hwdata;
      if (w_tout)
        {rxto_q, tot_q} <= {hwdata[15:8], 8'(rkc_clamp({8'h0, hwdata[7:0]}, 16'h1, 16'hFF))};
      if (w_mask)
        mask_q <= hwdata;
      if (w_pwr)
        pwr_q <= 6'(rkc_clamp({10'h0, hwdata[5:0]}, 16'(`RKC_PWR_MIN), 16'(`RKC_PWR_DEF)));
      if (w_rxf)
        rxf_q <= hwdata;
      if (w_txf)
        txf_q <= hwdata;
      if (w_unit)
      begin
        unit_q <= rkc_clamp(hwdata[15:0], `RKC_UNIT_MIN, `RKC_UNIT_MAX);
        sim_q <= 7'(rkc_clamp({9'h0, hwdata[22:16]}, 16'h0, 16'(`RKC_SIM_MAX)));
      end
      if (w_modem && hwdata[1:0] != 2'h3)
        modem_q <= rkc_modem_t'(hwdata[1:0]);
      if (c_init)
      begin
        dly_q.cts <= 8'h0;
        dly_q.keyup <= 8'h0;
        dly_q.rel <= 8'h0;
        ctrl_q[`RKC_C_KOD] <= 1'b1;
        ctrl_q[`RKC_C_CTSKEY] <= 1'b0;
        ctrl_q[`RKC_C_TOTEN] <= 1'b1;
        tot_q <= `RKC_TOT_DEF;
        pwr_q <= `RKC_PWR_DEF;
      end
      if (c_solo)
      begin
        ctrl_q[`RKC_C_APOL] <= 1'b1;
        ctrl_q[`RKC_C_RXEN] <= 1'b0;
        mask_q <= `RKC_MASK_SOLO;
      end
      if (c_chas)
      begin
        ctrl_q[`RKC_C_APOL] <= 1'b0;
        ctrl_q[`RKC_C_RXEN] <= 1'b1;
        mask_q <= `RKC_MASK_CHAS;
        rxto_q <= `RKC_RXTO_CHAS;
      end
    end
  end

  // timers
  rkc_tick_count #(.W(8)) u_gap (.hclk(hclk), .hresetn(hresetn), .clr(char_rx_i),
    .tick(ms_tick), .cnt_q(gap_cnt));
  rkc_tick_count #(.W(8)) u_cts (.hclk(hclk), .hresetn(hresetn), .clr(!rts_s_q),
    .tick(ms_tick), .cnt_q(cts_cnt));
  // keying timers are one bit wider so that a count one past 255 stays reachable
  rkc_tick_count #(.W(9)) u_ku (.hclk(hclk), .hresetn(hresetn), .clr(st_q != st_d),
    .tick(ms_tick), .cnt_q(ku_cnt));
  rkc_tick_count #(.W(9)) u_tot (.hclk(hclk), .hresetn(hresetn), .clr(!tx_on),
    .tick(sec_tick), .cnt_q(tot_cnt));
  rkc_tick_count #(.W(8)) u_rx (.hclk(hclk), .hresetn(hresetn),
    .clr(rf_data_i || !ctrl_q[`RKC_C_RXEN]), .tick(min_tick), .cnt_q(rx_cnt));

  // message gap, key-on-data activity
  assign gap_done = (gap_cnt >= dly_q.gap);
  assign new_msg_o = new_msg_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {first_q, new_msg_q, data_act_q} <= 3'b100;
    else
    begin
      new_msg_q <= char_rx_i && (first_q || gap_done);
      first_q <= first_q && !char_rx_i;
      data_act_q <= char_rx_i || (data_act_q && !gap_done);
    end
  end

  // combined keying request
  assign req = ptt_s_q || (rts_s_q && !ctrl_q[`RKC_C_CTSKEY]) || key_cmd_q
    || ctrl_q[`RKC_C_CONTINUOUS_KEY] || (ctrl_q[`RKC_C_KOD] && data_act_q);
  assign tx_on = (st_q == KS_ON) || (st_q == KS_HOLD);
  assign tx_key_o = tx_on;
  // one tick past the setting: the free-running tick may land just after a restart
  assign tot_fire = ctrl_q[`RKC_C_TOTEN] && tx_on && (tot_cnt > {1'b0, tot_q});

  // keying sequencer
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      KS_IDLE:
        if (req && !lock_q)
          st_d = (dly_q.keyup == 8'h0) ? KS_ON : KS_WAIT;
      KS_WAIT:
        if (!req)
          st_d = KS_IDLE;
        else if (ku_cnt > {1'b0, dly_q.keyup})
          st_d = KS_ON;
      KS_ON:
        if (tot_fire)
          st_d = KS_IDLE;
        else if (!req)
          st_d = (dly_q.rel == 8'h0) ? KS_IDLE : KS_HOLD;
      default:
        if (tot_fire)
          st_d = KS_IDLE;
        else if (req)
          st_d = KS_ON;
        else if (ku_cnt > {1'b0, dly_q.rel})
          st_d = KS_IDLE;
    endcase
  end

  // sequencer state, key command latch, time-out lockout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= KS_IDLE;
      key_cmd_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (w_cmd && hwdata[`RKC_K_UNKEY])
        key_cmd_q <= 1'b0;
      else if (w_cmd && hwdata[`RKC_K_KEY])
        key_cmd_q <= 1'b1;
      lock_q <= tot_fire || (lock_q && req);
    end
  end

  // clear-to-send
  assign cts_o = ctrl_q[`RKC_C_CTSKEY] ? rf_data_i : (rts_s_q && (cts_cnt >= dly_q.cts));

  // alarm events, set wins over software clear
  assign rxto_fire = ctrl_q[`RKC_C_RXEN] && (rx_cnt >= rxto_q);
  assign evt_set = alarm_evt_i | (32'(rxto_fire) << `RKC_EVT_RXTO);
  assign gated = evt_q & {mask_q[15:0], mask_q[31:16]};
  assign alarm_o = ctrl_q[`RKC_C_APOL] ? (|gated) : !(|gated);
  assign cur_code = evt_q[ptr_q] ? ptr_q : rkc_next(evt_q, ptr_q);
  assign none = (evt_q == 32'h0);
  assign more = |(evt_q & ~(32'h1 << cur_code));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {evt_q, ptr_q} <= {32'h0, 5'h0};
    else
    begin
      evt_q <= (evt_q & ~(w_evt ? hwdata : 32'h0)) | evt_set;
      if (w_rpt)
        ptr_q <= rkc_next(evt_q, cur_code);
    end
  end

  // signal quality samples
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {snr_q, snr_div_q, rssi_q} <= {`RKC_SNR_MIN, 2'h0, `RKC_RSSI_LO};
    else
    begin
      if (sec_tick)
        snr_div_q <= (snr_div_q == 2'(SNR_SEC - 1)) ? 2'h0 : snr_div_q + 2'h1;
      if (sec_tick && snr_div_q == 2'(SNR_SEC - 1))
        snr_q <= 6'(rkc_clamp({10'h0, snr_i}, 16'(`RKC_SNR_MIN), 16'(`RKC_SNR_MAX)));
      if ($signed(rssi_i) > $signed(`RKC_RSSI_HI))
        rssi_q <= `RKC_RSSI_HI;
      else if ($signed(rssi_i) < $signed(`RKC_RSSI_LO))
        rssi_q <= `RKC_RSSI_LO;
      else
        rssi_q <= rssi_i;
    end
  end

  // read multiplexer
  always_comb
  begin
    if (ap_q.addr == `RKC_A_CTRL)
      rd_mux = {24'h0, ctrl_q};
    else if (ap_q.addr == `RKC_A_DLY)
      rd_mux = dly_q;
    else if (ap_q.addr == `RKC_A_TOUT)
      rd_mux = {16'h0, rxto_q, tot_q};
    else if (ap_q.addr == `RKC_A_MASK)
      rd_mux = mask_q;
    else if (ap_q.addr == `RKC_A_PWR)
      rd_mux = {26'h0, pwr_q};
    else if (ap_q.addr == `RKC_A_RXF)
      rd_mux = rxf_q;
    else if (ap_q.addr == `RKC_A_TXF)
      rd_mux = txf_q;
    else if (ap_q.addr == `RKC_A_UNIT)
      rd_mux = {9'h0, sim_q, unit_q};
    else if (ap_q.addr == `RKC_A_MODEM)
      rd_mux = {30'h0, modem_q};
    else if (ap_q.addr == `RKC_A_STAT)
      rd_mux = {27'h0, lock_q, alarm_o, cts_o, key_cmd_q, tx_on};
    else if (ap_q.addr == `RKC_A_EVT)
      rd_mux = evt_q;
    else if (ap_q.addr == `RKC_A_RPT)
      rd_mux = {24'h0, none, more, cur_code < `RKC_MAJOR_LIM, cur_code};
    else if (ap_q.addr == `RKC_A_SIG)
      rd_mux = {18'h0, snr_q, rssi_q};
    else
      rd_mux = 32'h0;
  end

  // checks
  property p_keyup;
    @(posedge hclk) disable iff (!hresetn)
    $rose(tx_key_o) && dly_q.keyup != 8'h0 |-> $past(ku_cnt) > {1'b0, dly_q.keyup};
  endproperty
  a_keyup: assert property (p_keyup) else $error("keyed before delay");
  property p_rel0;
    @(posedge hclk) disable iff (!hresetn)
    st_q == KS_ON && !req && dly_q.rel == 8'h0 |=> !tx_key_o;
  endproperty
  a_rel0: assert property (p_rel0) else $error("zero release held");
  property p_tot;
    @(posedge hclk) disable iff (!hresetn)
    tot_fire |=> !tx_key_o && lock_q;
  endproperty
  a_tot: assert property (p_tot) else $error("time-out not unkeyed");
  property p_lock;
    @(posedge hclk) disable iff (!hresetn)
    lock_q && req |=> !tx_key_o ##1 !tx_key_o;
  endproperty
  a_lock: assert property (p_lock) else $error("keyed while locked");
  property p_cts;
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_q[`RKC_C_CTSKEY] && $rose(rts_s_q) && dly_q.cts != 8'h0 |-> !cts_o;
  endproperty
  a_cts: assert property (p_cts) else $error("cts early");
  property p_gap;
    @(posedge hclk) disable iff (!hresetn)
    char_rx_i && gap_done |=> new_msg_o;
  endproperty
  a_gap: assert property (p_gap) else $error("new message missed");
  property p_rxto;
    @(posedge hclk) disable iff (!hresetn)
    rxto_fire |=> evt_q[`RKC_EVT_RXTO];
  endproperty
  a_rxto: assert property (p_rxto) else $error("event 12 missing");
  property p_pwr;
    @(posedge hclk) disable iff (!hresetn)
    pwr_q >= `RKC_PWR_MIN && pwr_q <= `RKC_PWR_DEF;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power out of range");
  property p_init;
    @(posedge hclk) disable iff (!hresetn)
    c_init |=> pwr_q == `RKC_PWR_DEF && tot_q == `RKC_TOT_DEF && ctrl_q[`RKC_C_TOTEN];
  endproperty
  a_init: assert property (p_init) else $error("restore incomplete");
  c_key: cover property (@(posedge hclk) disable iff (!hresetn) $rose(tx_key_o));
  c_tot: cover property (@(posedge hclk) disable iff (!hresetn) tot_fire);
  c_step: cover property (@(posedge hclk) disable iff (!hresetn) w_rpt && more);
  c_msg: cover property (@(posedge hclk) disable iff (!hresetn) new_msg_o);
endmodule

/* rkc_defs.svh */
`ifndef RKC_DEFS_SVH
`define RKC_DEFS_SVH
// register byte offsets
`define RKC_A_CTRL 8'h00
`define RKC_A_CMD 8'h04
`define RKC_A_DLY 8'h08
`define RKC_A_TOUT 8'h0C
`define RKC_A_MASK 8'h10
`define RKC_A_PWR 8'h14
`define RKC_A_RXF 8'h18
`define RKC_A_TXF 8'h1C
`define RKC_A_UNIT 8'h20
`define RKC_A_MODEM 8'h24
`define RKC_A_STAT 8'h28
`define RKC_A_EVT 8'h2C
`define RKC_A_RPT 8'h30
`define RKC_A_SIG 8'h34
// control bit positions
`define RKC_C_CONTINUOUS_KEY 0
`define RKC_C_KOD 1
`define RKC_C_CTSKEY 2
`define RKC_C_TOTEN 3
`define RKC_C_ROOT 4
`define RKC_C_SIM 5
`define RKC_C_APOL 6
`define RKC_C_RXEN 7
// command bit positions
`define RKC_K_INIT 0
`define RKC_K_SOLO 1
`define RKC_K_CHAS 2
`define RKC_K_KEY 3
`define RKC_K_UNKEY 4
// reset and restore values
`define RKC_CTRL_RST 8'h4A
`define RKC_TOT_DEF 8'h1E
`define RKC_PWR_DEF 6'h25
`define RKC_PWR_MIN 6'h14
`define RKC_MASK_SOLO 32'hFFFFFFFF
`define RKC_MASK_CHAS 32'hFFFF0000
`define RKC_RXTO_CHAS 8'h14
`define RKC_UNIT_MIN 16'h2710
`define RKC_UNIT_MAX 16'hFDE8
`define RKC_SIM_MAX 7'h50
`define RKC_SNR_MIN 6'h0A
`define RKC_SNR_MAX 6'h21
`define RKC_RSSI_HI 8'hCE
`define RKC_RSSI_LO 8'h88
`define RKC_EVT_RXTO 12
`define RKC_MAJOR_LIM 5'h10
`define RKC_FREQ_STEP_HZ 6250
// timing
`define RKC_CLK_NS 10
`define RKC_MS_NS 1000000
`define RKC_SEC_MS 1000
`define RKC_MIN_SEC 60
`define RKC_SNR_SEC 2
`endif

/* rkc_pkg.sv */
package rkc_pkg;
  // keying sequencer states
  typedef enum logic [1:0] {KS_IDLE, KS_WAIT, KS_ON, KS_HOLD} rkc_key_st_t;
  // modem selection
  typedef enum logic [1:0] {MD_ANALOG, MD_9600, MD_19200} rkc_modem_t;
  // delay register layout
  typedef struct packed {
    logic [7:0] gap;
    logic [7:0] cts;
    logic [7:0] rel;
    logic [7:0] keyup;
  } rkc_dly_t;
  // captured bus address phase
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic vld;
  } rkc_ap_t;
endpackage

/* rkc_tick_count.sv */
`timescale 1ns/100ps
module rkc_tick_count #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clr,
  input wire logic tick,
  // count
  output logic [W-1:0] cnt_q
);
  logic [W-1:0] cnt_d;

  // saturating tick counter, clear has priority
  assign cnt_d = clr ? '0 : ((tick && !(&cnt_q)) ? cnt_q + 1'b1 : cnt_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

/* rkc_dte_model.sv */
`timescale 1ns/100ps
module rkc_dte_model (
  // clock
  input wire logic hclk,
  // requests from the bench
  input wire logic ptt_req,
  input wire logic rts_req,
  input wire logic chr_req,
  input wire logic [31:0] evt_req,
  // lines into the device
  output logic ptt_i,
  output logic rts_i,
  output logic char_rx_i,
  output logic rf_data_i,
  output logic [31:0] alarm_evt_i,
  output logic [5:0] snr_i,
  output logic [7:0] rssi_i
);
  // keying, character and alarm lines follow the bench one clock later
  always_ff @(posedge hclk)
  begin
    ptt_i <= ptt_req;
    rts_i <= rts_req;
    char_rx_i <= chr_req;
    alarm_evt_i <= evt_req;
  end
  // receiver side stays quiet, samples fixed
  assign rf_data_i = 1'b0;
  assign snr_i = 6'h18;
  assign rssi_i = 8'hB0;
endmodule

/* rkc_ctrl_tb_top.sv */
`timescale 1ns/100ps
module rkc_ctrl_tb_top;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} rkc_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cts_o, tx_key_o, new_msg_o, alarm_o;
  logic [31:0] haddr, hwdata, hrdata, alarm_evt_i, evt_req, r;
  logic [1:0] htrans;
  logic ptt_i, rts_i, char_rx_i, rf_data_i, ptt_req, rts_req, chr_req;
  logic [5:0] snr_i;
  logic [7:0] rssi_i;
  int fail_count, n_tests, cyc, n, i;
  rkc_row_t rows [14];
  // device with shortened timebases: 1 ms = 10, 1 s = 40, 1 min = 80 cycles
  rkc_ctrl #(.MS_CYCLES(10), .SEC_MS(4), .MIN_SEC(2)) u_rkc_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ptt_i(ptt_i), .rts_i(rts_i),
    .cts_o(cts_o), .tx_key_o(tx_key_o), .char_rx_i(char_rx_i), .rf_data_i(rf_data_i),
    .new_msg_o(new_msg_o), .alarm_evt_i(alarm_evt_i), .snr_i(snr_i), .rssi_i(rssi_i),
    .alarm_o(alarm_o));
  rkc_dte_model u_rkc_dte_model (
    .hclk(hclk), .ptt_req(ptt_req), .rts_req(rts_req), .chr_req(chr_req),
    .evt_req(evt_req), .ptt_i(ptt_i), .rts_i(rts_i), .char_rx_i(char_rx_i),
    .rf_data_i(rf_data_i), .alarm_evt_i(alarm_evt_i), .snr_i(snr_i), .rssi_i(rssi_i));
  // clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single word transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // cycles until the transmitter reaches level v
  task automatic wait_tx(input logic v);
    n = 0;
    while (tx_key_o !== v && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ptt_req = 1'b0;
    rts_req = 1'b0;
    chr_req = 1'b0;
    evt_req = 32'h0;
    rows = '{
      '{8'h00, 1'b0, 32'h0, 32'h0000004A}, '{8'h10, 1'b0, 32'h0, 32'hFFFFFFFF},
      '{8'h14, 1'b0, 32'h0, 32'h00000025}, '{8'h08, 1'b0, 32'h0, 32'h00000000},
      '{8'h14, 1'b1, 32'h0000000A, 32'h00000014}, '{8'h14, 1'b1, 32'h00000028, 32'h00000025},
      '{8'h20, 1'b1, 32'h007F0001, 32'h00502710}, '{8'h20, 1'b1, 32'h0005FFFF, 32'h0005FDE8},
      '{8'h24, 1'b1, 32'h00000002, 32'h00000002}, '{8'h24, 1'b1, 32'h00000003, 32'h00000002},
      '{8'h0C, 1'b1, 32'h00000000, 32'h00000001}, '{8'h18, 1'b1, 32'h00000005, 32'h00000005},
      '{8'h3C, 1'b1, 32'h12345678, 32'h00000000}, '{8'h00, 1'b1, 32'h00000058, 32'h00000058}};
    idle(16);
    hresetn <= 1'b1;
    // register table: reset values, clamps, unmapped place, role bit
    for (i = 0; i < 14; i++)
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].e, "register row");
    end
    // factory restore keeps the gap time only
    bus(1'b1, 8'h08, 32'h05030302);
    bus(1'b1, 8'h04, 32'h00000001);
    bus(1'b0, 8'h08, 32'h0);
    chk(r, 32'h05000000, "restore delays");
    bus(1'b0, 8'h14, 32'h0);
    chk(r, 32'h00000025, "restore power");
    bus(1'b0, 8'h0C, 32'h0);
    chk(r & 32'hFF, 32'h0000001E, "restore tx timeout");
    bus(1'b0, 8'h00, 32'h0);
    chk(r & 32'h1E, 32'h0000001A, "restore control");
    // push-to-talk with key-up 3 ms and release 2 ms
    bus(1'b1, 8'h00, 32'h00000040);
    bus(1'b1, 8'h08, 32'h00000203);
    ptt_req <= 1'b1;
    wait_tx(1'b1);
    chk(n >= 35 && n <= 46, 1, "key-up delay");
    ptt_req <= 1'b0;
    wait_tx(1'b0);
    chk(n >= 25 && n <= 36, 1, "release delay");
    // key command holds until unkey command, zero delays
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, 32'h00000008);
    idle(200);
    chk(tx_key_o, 1'b1, "key command");
    bus(1'b1, 8'h04, 32'h00000010);
    wait_tx(1'b0);
    chk(n <= 3, 1, "unkey command");
    // latching transmit time-out of 2 s on request-to-send
    bus(1'b1, 8'h00, 32'h00000048);
    bus(1'b1, 8'h0C, 32'h00000002);
    rts_req <= 1'b1;
    wait_tx(1'b1);
    chk(cts_o, 1'b1, "clear to send");
    wait_tx(1'b0);
    chk(n >= 81 && n <= 121, 1, "time-out");
    idle(100);
    chk(tx_key_o, 1'b0, "latched off");
    rts_req <= 1'b0;
    idle(6);
    rts_req <= 1'b1;
    wait_tx(1'b1);
    chk(n <= 6, 1, "rekey after removal");
    rts_req <= 1'b0;
    idle(10);
    // message gap of 2 ms
    bus(1'b1, 8'h08, 32'h02000000);
    for (i = 0; i < 3; i++)
    begin
      idle(i == 1 ? 5 : 40);
      chr_req <= 1'b1;
      idle(1);
      chr_req <= 1'b0;
      idle(2);
      chk(new_msg_o, i != 1, "new message");
    end
    // chassis restore: active low, major mask, 20 minute receive time-out
    bus(1'b1, 8'h04, 32'h00000004);
    bus(1'b0, 8'h00, 32'h0);
    chk(r & 32'hC0, 32'h00000080, "chassis control");
    bus(1'b0, 8'h10, 32'h0);
    chk(r, 32'hFFFF0000, "chassis mask");
    bus(1'b0, 8'h0C, 32'h0);
    chk(r & 32'hFF00, 32'h00001400, "chassis rx time");
    evt_req <= 32'h00020000;
    idle(1);
    evt_req <= 32'h0;
    idle(4);
    chk(alarm_o, 1'b1, "minor masked");
    evt_req <= 32'h00000010;
    idle(1);
    evt_req <= 32'h0;
    idle(4);
    chk(alarm_o, 1'b0, "major active low");
    bus(1'b1, 8'h2C, 32'h00020010);
    idle(2);
    chk(alarm_o, 1'b1, "alarm cleared");
    // standalone restore
    bus(1'b1, 8'h04, 32'h00000002);
    bus(1'b0, 8'h00, 32'h0);
    chk(r & 32'hC0, 32'h00000040, "standalone control");
    bus(1'b0, 8'h10, 32'h0);
    chk(r, 32'hFFFFFFFF, "standalone mask");
    chk(alarm_o, 1'b0, "idle active high");
    // one minute receive time-out raises event 12; report steps through pending codes
    bus(1'b1, 8'h0C, 32'h00000102);
    bus(1'b1, 8'h00, 32'h000000C8);
    evt_req <= 32'h00020000;
    idle(1);
    evt_req <= 32'h0;
    idle(170);
    bus(1'b0, 8'h2C, 32'h0);
    chk(r, 32'h00021000, "rx time-out event");
    chk(alarm_o, 1'b1, "alarm active high");
    bus(1'b0, 8'h30, 32'h0);
    chk(r, 32'h0000006C, "report major with more");
    bus(1'b1, 8'h30, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    chk(r, 32'h00000051, "report next minor");
    // receive timer off, key on data on, every event cleared
    bus(1'b1, 8'h00, 32'h0000004A);
    bus(1'b1, 8'h2C, 32'hFFFFFFFF);
    bus(1'b0, 8'h30, 32'h0);
    chk(r & 32'hE0, 32'h00000080, "report none");
    bus(1'b0, 8'h34, 32'h0);
    chk(r, 32'h000018B0, "signal quality");
    // clear-to-send 3 ms after request-to-send
    bus(1'b1, 8'h08, 32'h02030000);
    rts_req <= 1'b1;
    idle(4);
    chk(cts_o, 1'b0, "cts held");
    idle(40);
    chk(cts_o, 1'b1, "cts after delay");
    rts_req <= 1'b0;
    idle(8);
    // one received character keys the transmitter until the gap elapses
    chr_req <= 1'b1;
    idle(1);
    chr_req <= 1'b0;
    wait_tx(1'b1);
    chk(n <= 4, 1, "key on data");
    wait_tx(1'b0);
    chk(n <= 25, 1, "data key release");
    final_report();
  end
endmodule
